/* File: rtl/ctl_load_exec.sv */
// Executes the clock control, timer flag and prescaler load instructions.
// Assumes the core sequencer presents opcode, accumulator and second work
// register on the core clock, with a one-cycle execute strobe per word.
`timescale 1ns/1ps
`default_nettype none
module ctl_load_exec
  import ctl_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic exec_strobe,
  input wire logic [9:0] opcode,
  input wire logic [3:0] acc,
  input wire logic [3:0] breg,
  output logic [3:0] clock_control_reg,
  output logic timer_control_flag,
  output logic [7:0] prescaler_counter,
  output logic [7:0] prescaler_reload_reg,
  output logic prescaler_load_pulse,
  output logic instr_done,
  output logic skip_next,
  output logic carry_write,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic en;             // Decoder enable, software controlled
    logic [3:0] clk_ctl;  // Clock control register
    logic tflag;          // Timer control bit
    logic [7:0] count;    // Prescaler counter value
    logic [7:0] reload;   // Prescaler reload value
    logic ld_pulse;       // Prescaler was just loaded
    logic done;           // An instruction of ours just completed
    logic skip;           // Skip request towards the sequencer, never raised
    logic cy_wr;          // Carry write request, never raised
    logic [31:0] rdata;   // APB read data
    logic ready;          // APB ready
    logic err;            // APB error
  } ctl_state_t;

  ctl_state_t st_r;
  ctl_state_t st_nxt;
  ctl_kind_t kind;

  // Opcode decode, shared by execute and checks
  function automatic ctl_kind_t decode(input logic [9:0] op);
    case (op)
      CTL_OP_CLOCK_CTRL_LOAD: decode = CTL_K_CLOCK;
      CTL_OP_TIMER_FLAG_LOAD: decode = CTL_K_TFLAG;
      CTL_OP_PRESCALER_LOAD: decode = CTL_K_PRESC;
      default: decode = CTL_K_NONE;
    endcase
  endfunction

  // Address check, used for the error response only
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == CTL_ADDR_CTRL) || (a == CTL_ADDR_CLKCTL) ||
             (a == CTL_ADDR_TFLAG) || (a == CTL_ADDR_PRESC);
  endfunction

  assign kind = decode(opcode);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.ld_pulse = 1'b0;
    st_nxt.done = 1'b0;
    // These loads never skip and never write the carry; kept as flops for clean outputs
    st_nxt.skip = 1'b0;
    st_nxt.cy_wr = 1'b0;
    // Instruction execute: single cycle, result visible next edge
    if (exec_strobe && st_r.en && kind != CTL_K_NONE)
    begin
      st_nxt.done = 1'b1;
      case (kind)
        CTL_K_CLOCK:
        begin
          st_nxt.clk_ctl = acc;
        end
        CTL_K_TFLAG:
        begin
          st_nxt.tflag = acc[0];
        end
        CTL_K_PRESC:
        begin
          // Counter and reload get the same byte
          st_nxt.count = {breg, acc};
          st_nxt.reload = {breg, acc};
          st_nxt.ld_pulse = 1'b1;
        end
        default:
        begin
          st_nxt.done = 1'b0;
        end
      endcase
    end
    // APB: ready one cycle into the access phase, then drop
    if (psel && penable && !st_r.ready)
    begin
      st_nxt.ready = 1'b1;
      st_nxt.err = !mapped(paddr);
      st_nxt.rdata = 32'h0000_0000;
      case (paddr)
        CTL_ADDR_CTRL: st_nxt.rdata[CTL_CTRL_EN_BIT] = st_r.en;
        CTL_ADDR_CLKCTL: st_nxt.rdata[3:0] = st_r.clk_ctl;
        CTL_ADDR_TFLAG: st_nxt.rdata[0] = st_r.tflag;
        CTL_ADDR_PRESC:
        begin
          st_nxt.rdata[CTL_PRESC_RELOAD_LSB +: 8] = st_r.reload;
          st_nxt.rdata[CTL_PRESC_COUNT_LSB +: 8] = st_r.count;
        end
        default: st_nxt.rdata = 32'h0000_0000;
      endcase
    end
    else
    begin
      st_nxt.ready = 1'b0;
      st_nxt.err = 1'b0;
    end
    // Write takes effect only at the completing edge; others are read-only
    if (psel && penable && st_r.ready && pwrite && paddr == CTL_ADDR_CTRL)
    begin
      st_nxt.en = pwdata[CTL_CTRL_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_r <= '{en: CTL_CTRL_EN_RST, clk_ctl: CTL_CLKCTL_RST, tflag: CTL_TFLAG_RST,
                count: CTL_PRESC_RST, reload: CTL_PRESC_RST, ld_pulse: 1'b0,
                done: 1'b0, skip: 1'b0, cy_wr: 1'b0, rdata: 32'h0000_0000,
                ready: 1'b0, err: 1'b0};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from state; these loads never skip or touch carry
  assign clock_control_reg = st_r.clk_ctl;
  assign timer_control_flag = st_r.tflag;
  assign prescaler_counter = st_r.count;
  assign prescaler_reload_reg = st_r.reload;
  assign prescaler_load_pulse = st_r.ld_pulse;
  assign instr_done = st_r.done;
  assign skip_next = st_r.skip;
  assign carry_write = st_r.cy_wr;
  assign prdata = st_r.rdata;
  assign pready = st_r.ready;
  assign pslverr = st_r.err;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_exec(ctl_kind_t k);
    exec_strobe && st_r.en && kind == k;
  endsequence

  a_clock_ctrl_copy: assert property (s_exec(CTL_K_CLOCK) |=>
    clock_control_reg == $past(acc) && instr_done)
    else $error("clock control not loaded from accumulator");

  a_tflag_bit0: assert property (s_exec(CTL_K_TFLAG) |=>
    timer_control_flag == $past(acc[0]) && clock_control_reg == $past(clock_control_reg))
    else $error("timer flag not loaded from accumulator bit 0");

  a_presc_high: assert property (s_exec(CTL_K_PRESC) |=>
    prescaler_counter[7:4] == $past(breg) && prescaler_reload_reg[7:4] == $past(breg))
    else $error("prescaler high nibble not from second register");

  a_presc_low: assert property (s_exec(CTL_K_PRESC) |=>
    prescaler_counter[3:0] == $past(acc) && prescaler_reload_reg == prescaler_counter
    && prescaler_load_pulse)
    else $error("prescaler low nibble or pair mismatch");

  // Load pulse lasts one cycle unless another prescaler load follows at once
  a_pulse_single: assert property (
    prescaler_load_pulse && !(exec_strobe && st_r.en && kind == CTL_K_PRESC) |=>
    !prescaler_load_pulse)
    else $error("prescaler load pulse longer than one cycle");

  a_one_cycle: assert property (instr_done |->
    $past(exec_strobe) && !skip_next && !carry_write)
    else $error("completion without a one-cycle execute");

  // Decoder disabled by software: the word is dropped without a trace
  a_refused_off: assert property (exec_strobe && !st_r.en |=>
    !instr_done && !prescaler_load_pulse && clock_control_reg == $past(clock_control_reg))
    else $error("load executed while decoder disabled");

  // Words that are not ours must not complete or touch our registers
  a_other_ignored: assert property (exec_strobe && kind == CTL_K_NONE |=>
    !instr_done && clock_control_reg == $past(clock_control_reg))
    else $error("foreign opcode executed");

  // Bus answer comes one cycle into the access phase
  a_access_answer: assert property (psel && penable && !pready |=> pready)
    else $error("bus access not answered after one wait state");

  // Ready is a one-cycle pulse, so a held access is not answered on two cycles in a row
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("bus ready held for more than one cycle");
endmodule
`default_nettype wire

/* File: rtl/ctl_pkg.sv */
// Package for the clock/timer register load executor.
// Assumes one core clock and the core's active-low asynchronous reset.
`default_nettype none
package ctl_pkg;
  // Opcodes of the three transfer instructions (10-bit words)
  localparam logic [9:0] CTL_OP_CLOCK_CTRL_LOAD = 10'h216;
  localparam logic [9:0] CTL_OP_TIMER_FLAG_LOAD = 10'h2AA;
  localparam logic [9:0] CTL_OP_PRESCALER_LOAD = 10'h235;
  // APB byte addresses
  localparam logic [7:0] CTL_ADDR_CTRL = 8'h00;
  localparam logic [7:0] CTL_ADDR_CLKCTL = 8'h04;
  localparam logic [7:0] CTL_ADDR_TFLAG = 8'h08;
  localparam logic [7:0] CTL_ADDR_PRESC = 8'h0C;
  // Field positions
  localparam int CTL_CTRL_EN_BIT = 0;
  localparam int CTL_PRESC_RELOAD_LSB = 0;
  localparam int CTL_PRESC_COUNT_LSB = 8;
  // Reset values
  localparam logic CTL_CTRL_EN_RST = 1'b1;
  localparam logic [3:0] CTL_CLKCTL_RST = 4'h0;
  localparam logic CTL_TFLAG_RST = 1'b0;
  localparam logic [7:0] CTL_PRESC_RST = 8'h00;
  // Decoded instruction kind
  typedef enum logic [1:0] {
    CTL_K_NONE = 2'b00,
    CTL_K_CLOCK = 2'b01,
    CTL_K_TFLAG = 2'b10,
    CTL_K_PRESC = 2'b11
  } ctl_kind_t;
endpackage
`default_nettype wire

/* File: testbench/ctl_seq_model.sv */
// Model of the core sequencer: hands over one load word at a time.
// Assumes ref_clk comes from the bench; drives just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module ctl_seq_model
(
  input wire logic ref_clk,
  output logic exec_strobe,
  output logic [9:0] opcode,
  output logic [3:0] acc,
  output logic [3:0] breg
);
  // Quiet until the first word
  initial
  begin
    exec_strobe = 1'b0;
    opcode = 10'h000;
    acc = 4'h0;
    breg = 4'h0;
  end
  // One strobe cycle per word; operands inverted afterwards so stale data cannot pass
  task automatic issue(input logic [9:0] op, input logic [3:0] a, input logic [3:0] b);
    @(posedge ref_clk);
    exec_strobe <= 1'b1;
    opcode <= op;
    acc <= a;
    breg <= b;
    @(posedge ref_clk);
    exec_strobe <= 1'b0;
    opcode <= ~op;
    acc <= ~a;
    breg <= ~b;
  endtask
  // Two words on consecutive edges, strobe held high between them
  task automatic issue2(input logic [9:0] op1, input logic [3:0] a1, input logic [3:0] b1,
                        input logic [9:0] op2, input logic [3:0] a2, input logic [3:0] b2);
    @(posedge ref_clk);
    exec_strobe <= 1'b1;
    opcode <= op1;
    acc <= a1;
    breg <= b1;
    @(posedge ref_clk);
    opcode <= op2;
    acc <= a2;
    breg <= b2;
    @(posedge ref_clk);
    exec_strobe <= 1'b0;
    opcode <= ~op2;
    acc <= ~a2;
    breg <= ~b2;
  endtask
endmodule
`default_nettype wire

/* File: testbench/tb.sv */
// Bench for the load executor: sequencer model plus an APB master.
// Assumes loads answer one cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ctl_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic stb, done, skip, cyw, tcf, ppul, pready, pslverr, err;
  logic [9:0] op;
  logic [3:0] acc, breg, ccr;
  logic [7:0] pcnt, prel;
  logic [31:0] prdata, rd;
  int mismatches = 0;
  int check_count = 0;
  always #25 ref_clk = ~ref_clk;
  ctl_seq_model seq (.ref_clk(ref_clk), .exec_strobe(stb), .opcode(op), .acc(acc), .breg(breg));
  ctl_load_exec dut (.ref_clk(ref_clk), .rst_b(rst_b), .exec_strobe(stb), .opcode(op),
    .acc(acc), .breg(breg), .clock_control_reg(ccr), .timer_control_flag(tcf),
    .prescaler_counter(pcnt), .prescaler_reload_reg(prel), .prescaler_load_pulse(ppul),
    .instr_done(done), .skip_next(skip), .carry_write(cyw), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  ////////////////////////////////////////////////////////////////////////////
  // Shared compare
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // APB transfer; waits for pready, only the watchdog ends a dead wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge ref_clk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_loads;
    seq.issue(CTL_OP_CLOCK_CTRL_LOAD, 4'hB, 4'h3);
    #1;
    chk("clkctl", {28'h0, ccr}, 32'hB);
    chk("flags", {29'h0, done, skip, cyw}, 32'h4);
    @(posedge ref_clk);
    #1;
    chk("donepulse", {31'h0, done}, 32'h0);
    seq.issue(10'h217, 4'h7, 4'h7);
    #1;
    chk("otherop", {27'h0, ccr, done}, 32'h16);
    seq.issue(CTL_OP_TIMER_FLAG_LOAD, 4'hF, 4'h0);
    #1;
    chk("tflagf", {31'h0, tcf}, 32'h1);
    seq.issue(CTL_OP_TIMER_FLAG_LOAD, 4'hE, 4'h0);
    #1;
    chk("tflag0", {31'h0, tcf}, 32'h0);
    seq.issue(CTL_OP_TIMER_FLAG_LOAD, 4'h1, 4'h0);
    #1;
    chk("tflag1", {31'h0, tcf}, 32'h1);
    seq.issue(CTL_OP_PRESCALER_LOAD, 4'h5, 4'hA);
    #1;
    chk("presc", {16'h0, pcnt, prel}, 32'hA5A5);
    chk("ppulse", {30'h0, ppul, done}, 32'h3);
    @(posedge ref_clk);
    #1;
    chk("pulseoff", {30'h0, ppul, done}, 32'h0);
    chk("keep", {27'h0, ccr, tcf}, 32'h17);
  endtask
  // Register view, unmapped address, and a disabled decoder
  task automatic t_apb;
    apb(1'b0, CTL_ADDR_CTRL, 32'h0);
    chk("ctrl", rd, 32'h1);
    chk("ctrlerr", {31'h0, err}, 32'h0);
    apb(1'b0, CTL_ADDR_PRESC, 32'h0);
    chk("prescrd", rd, 32'hA5A5);
    apb(1'b0, CTL_ADDR_CLKCTL, 32'h0);
    chk("clkrd", rd, 32'hB);
    apb(1'b0, CTL_ADDR_TFLAG, 32'h0);
    chk("tflagrd", rd, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmap", {31'h0, err}, 32'h1);
    chk("unmaprd", rd, 32'h0);
    apb(1'b1, CTL_ADDR_CLKCTL, 32'hFFFF_FFFF);
    chk("roerr", {31'h0, err}, 32'h0);
    chk("ro", {28'h0, ccr}, 32'hB);
    apb(1'b1, CTL_ADDR_CTRL, 32'h0);
    seq.issue(CTL_OP_CLOCK_CTRL_LOAD, 4'h4, 4'h0);
    #1;
    chk("off", {27'h0, ccr, done}, 32'h16);
    apb(1'b1, CTL_ADDR_CTRL, 32'h1);
    seq.issue(CTL_OP_CLOCK_CTRL_LOAD, 4'h4, 4'h0);
    #1;
    chk("on", {27'h0, ccr, done}, 32'h9);
  endtask
  // Two loads on consecutive edges; both must take effect
  task automatic t_b2b;
    seq.issue2(CTL_OP_PRESCALER_LOAD, 4'hC, 4'h3, CTL_OP_CLOCK_CTRL_LOAD, 4'h6, 4'h0);
    #1;
    chk("b2bclk", {28'h0, ccr}, 32'h6);
    chk("b2bpresc", {16'h0, pcnt, prel}, 32'h3C3C);
    chk("b2bpulse", {30'h0, ppul, done}, 32'h1);
  endtask
  // Mid-run reset with the decoder disabled: everything returns to reset values
  task automatic t_reset;
    apb(1'b1, CTL_ADDR_CTRL, 32'h0);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    chk("rst2", {11'h0, ccr, pcnt, prel, tcf}, 32'h0);
    apb(1'b0, CTL_ADDR_CTRL, 32'h0);
    chk("rst2en", rd, 32'h1);
  endtask
  task automatic complete_run;
    $display("Checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Whole run needs under a hundred cycles; the watchdog allows two thousand
  initial
  begin
    #100000;
    mismatches++;
    complete_run();
  end
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    chk("rst", {11'h0, ccr, pcnt, prel, tcf}, 32'h0);
    chk("rstflags", {26'h0, done, ppul, skip, cyw, pready, pslverr}, 32'h0);
    chk("rstrd", prdata, 32'h0);
    t_loads();
    t_apb();
    t_b2b();
    t_reset();
    complete_run();
  end
endmodule
`default_nettype wire
